//--- include/ufm_pkg.sv
// constants and types shared by the fifo interrupt mode control block
package ufm_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h21;
  localparam logic [7:0] ADDR_MASK = 8'h22;
  localparam logic [7:0] ADDR_LEVEL = 8'h23;
  // ----------------------------------------------------------------
  // fifo_irq_mode_reg fields
  // ----------------------------------------------------------------
  localparam int BIT_WD_EN = 7;
  localparam int BIT_RX_THR_HI = 6;
  localparam int BIT_TX_THR_HI = 5;
  localparam int BIT_TX_THR_LO = 4;
  localparam int BIT_BIG = 3;
  localparam int BIT_BAUD_X2 = 2;
  localparam int BIT_RSVD = 1;
  localparam int BIT_BAUD_X1 = 0;
  localparam logic [7:0] MODE_WMASK = 8'hFD;
  // ----------------------------------------------------------------
  // status and mask fields
  // ----------------------------------------------------------------
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_WD = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int WD_BIT_TIMES = 64;
  localparam int DEPTH_SMALL = 8;
  localparam int DEPTH_BIG = 256;
  // ----------------------------------------------------------------
  // watchdog states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UFM_WD_IDLE = 2'b00,
    UFM_WD_COUNT = 2'b01,
    UFM_WD_EXPIRED = 2'b10
  } ufm_wd_e;
endpackage : ufm_pkg

//--- include/ufm_ctl_if.sv
// control and result signals between the mode control top and its helpers
`timescale 1ns/1ps
`default_nettype none
interface ufm_ctl_if #(parameter int CW = 9);
  logic wd_en;
  logic access;
  logic bit_tick;
  logic rx_has_data;
  logic wd_expired;
  logic [1:0] rx_thr;
  logic [1:0] tx_thr;
  logic big;
  logic tx_en;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_cnt;
  logic rx_req;
  logic tx_req;
  modport top (output wd_en, access, bit_tick, rx_has_data, rx_thr, tx_thr, big, tx_en,
    rx_cnt, tx_cnt, input wd_expired, rx_req, tx_req);
  modport wdog (input wd_en, access, bit_tick, rx_has_data, output wd_expired);
  modport thr (input rx_thr, tx_thr, big, tx_en, rx_cnt, tx_cnt, output rx_req, tx_req);
endinterface : ufm_ctl_if
`default_nettype wire

//--- rtl/ufm_watchdog.sv
// receive inactivity watchdog
`timescale 1ns/1ps
`default_nettype none
module ufm_watchdog import ufm_pkg::*; #(
  parameter int TICKS = WD_BIT_TIMES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // controls and result
  ufm_ctl_if.wdog w
);
  localparam int CNTW = $clog2(TICKS + 1);

  if (TICKS < 2) begin : g_chk
    $error("ufm_watchdog: TICKS must be at least 2");
  end

  ufm_wd_e st_r;
  ufm_wd_e st_nxt;
  logic [CNTW-1:0] cnt_r;
  logic [CNTW-1:0] cnt_nxt;
  logic restart;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    restart = !w.wd_en || !w.rx_has_data || w.access;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (restart) begin
      st_nxt = (w.wd_en && w.rx_has_data) ? UFM_WD_COUNT : UFM_WD_IDLE;
      cnt_nxt = '0;
    end else begin
      case (st_r)
        UFM_WD_IDLE: begin
          st_nxt = UFM_WD_COUNT;
          cnt_nxt = w.bit_tick ? CNTW'(1) : '0;
        end
        UFM_WD_COUNT: begin
          if (w.bit_tick) begin
            if (cnt_r == CNTW'(TICKS - 1)) begin
              st_nxt = UFM_WD_EXPIRED;
              cnt_nxt = '0;
            end else begin
              cnt_nxt = cnt_r + CNTW'(1);
            end
          end
        end
        UFM_WD_EXPIRED: begin
          st_nxt = UFM_WD_EXPIRED;
        end
        default: begin
          st_nxt = UFM_WD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= UFM_WD_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign w.wd_expired = (st_r == UFM_WD_EXPIRED);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNTW-1:0] h_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_r <= '0;
    end else if (restart) begin
      h_r <= '0;
    end else if (w.bit_tick && h_r != CNTW'(TICKS)) begin
      h_r <= h_r + CNTW'(1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  wd_expiry_time_a: assert property (w.wd_expired == (h_r == CNTW'(TICKS)))
    else $error("watchdog expiry does not match quiet tick count");
  wd_restart_a: assert property (w.access || !w.wd_en |=> !w.wd_expired)
    else $error("watchdog not restarted by access or disable");
endmodule : ufm_watchdog
`default_nettype wire

//--- rtl/ufm_thresh.sv
// receive fill and transmit empty threshold compare
`timescale 1ns/1ps
`default_nettype none
module ufm_thresh import ufm_pkg::*; #(
  parameter int CW = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // controls and result
  ufm_ctl_if.thr t
);
  if (DEPTH_BIG >= (1 << CW)) begin : g_chk
    $error("ufm_thresh: CW too narrow for the large fifo depth");
  end

  function automatic logic [CW-1:0] depth_of(input logic big);
    depth_of = big ? CW'(DEPTH_BIG) : CW'(DEPTH_SMALL);
  endfunction : depth_of

  // fill level that raises the receive request
  function automatic logic [CW-1:0] rx_level(input logic [1:0] code, input logic big);
    logic [CW-1:0] d;
    d = depth_of(big);
    case (code)
      2'b00: rx_level = CW'(1);
      2'b01: rx_level = d >> 1;
      2'b10: rx_level = d - (d >> 2);
      default: rx_level = d;
    endcase
  endfunction : rx_level

  // free positions needed for the transmit request
  function automatic logic [CW-1:0] tx_need(input logic [1:0] code, input logic big);
    logic [CW-1:0] d;
    d = depth_of(big);
    case (code)
      2'b00: tx_need = d;
      2'b01: tx_need = d - (d >> 2);
      2'b10: tx_need = d >> 1;
      default: tx_need = CW'(1);
    endcase
  endfunction : tx_need

  logic rx_req_r;
  logic rx_req_nxt;
  logic tx_req_r;
  logic tx_req_nxt;
  logic [CW-1:0] tx_free;

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_comb begin
    tx_free = (t.tx_cnt >= depth_of(t.big)) ? '0 : depth_of(t.big) - t.tx_cnt;
    rx_req_nxt = (t.rx_cnt >= rx_level(t.rx_thr, t.big));
    tx_req_nxt = t.tx_en && (tx_free >= tx_need(t.tx_thr, t.big));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_req_r <= 1'b0;
      tx_req_r <= 1'b0;
    end else begin
      rx_req_r <= rx_req_nxt;
      tx_req_r <= tx_req_nxt;
    end
  end

  assign t.rx_req = rx_req_r;
  assign t.tx_req = tx_req_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  rx_default_level_a: assert property (t.rx_thr == 2'b00 |=> t.rx_req == ($past(t.rx_cnt) != '0))
    else $error("receive request wrong at default threshold");
  tx_default_empty_a: assert property (t.tx_thr == 2'b00 && t.tx_en && t.tx_cnt == '0 |=> t.tx_req)
    else $error("transmit request missing with empty fifo");
  tx_withdraw_a: assert property (t.tx_thr == 2'b00 && t.tx_cnt != '0 |=> !t.tx_req)
    else $error("transmit request kept after a load");
endmodule : ufm_thresh
`default_nettype wire

//--- rtl/ufm_mode_ctrl.sv
// fifo interrupt mode control: mode register, thresholds, watchdog, interrupt
//
// Behaviour
// - mode bit 7 enables receive watchdog
// - watchdog fires after 64 quiet bit times
// - mode bit 6 is receive threshold msb
// - default receive threshold: request at one character
// - bits 5:4 set transmit free-space threshold
// - default transmit threshold: request only when empty
// - reset leaves transmit empty, request once enabled
// - one loaded character withdraws transmit request
// - bit 3 selects 8 or 256 depth
// - bit 2 selects second extended baud group
// - bit 1 reserved zero; bit 0 first group
`timescale 1ns/1ps
`default_nettype none
module ufm_mode_ctrl import ufm_pkg::*; #(
  parameter int CW = 9,
  parameter int WD_TICKS = WD_BIT_TIMES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // receive side
  input wire logic secondary_rx_thr_lo,
  input wire logic [CW-1:0] receive_queue_count,
  input wire logic receive_queue_access,
  input wire logic rx_bit_tick,
  // transmit side
  input wire logic [CW-1:0] tx_queue_count,
  input wire logic tx_enable,
  // mode outputs
  output logic rx_irq_req,
  output logic tx_irq_req,
  output logic fifo_big_mode,
  output logic baud_ext1,
  output logic baud_ext2,
  // interrupt
  output logic irq
);
  if (CW < 1 || DEPTH_BIG >= (1 << CW)) begin : g_chk
    $error("ufm_mode_ctrl: CW cannot hold the large fifo count");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rx_prev_r;
  logic tx_prev_r;
  logic wd_prev_r;
  logic [7:0] ev;
  logic [7:0] level;
  logic wr_mode;
  logic wr_mask;
  logic rd_stat;

  ufm_ctl_if #(.CW(CW)) ctl ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  ufm_watchdog #(.TICKS(WD_TICKS)) u_wdog (
    .clk(clk),
    .rstn(rstn),
    .w(ctl.wdog)
  );

  ufm_thresh #(.CW(CW)) u_thr (
    .clk(clk),
    .rstn(rstn),
    .t(ctl.thr)
  );

  // ----------------------------------------------------------------
  // control routing
  // ----------------------------------------------------------------
  assign ctl.wd_en = mode_r[BIT_WD_EN];
  assign ctl.access = receive_queue_access;
  assign ctl.bit_tick = rx_bit_tick;
  assign ctl.rx_has_data = (receive_queue_count != '0);
  assign ctl.rx_thr = {mode_r[BIT_RX_THR_HI], secondary_rx_thr_lo};
  assign ctl.tx_thr = mode_r[BIT_TX_THR_HI:BIT_TX_THR_LO];
  assign ctl.big = mode_r[BIT_BIG];
  assign ctl.tx_en = tx_enable;
  assign ctl.rx_cnt = receive_queue_count;
  assign ctl.tx_cnt = tx_queue_count;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_comb begin
    wr_mode = reg_wr && hit(reg_addr, ADDR_MODE);
    wr_mask = reg_wr && hit(reg_addr, ADDR_MASK);
    rd_stat = reg_rd && hit(reg_addr, ADDR_STAT);
    ev = 8'h00;
    ev[ST_RX] = ctl.rx_req && !rx_prev_r;
    ev[ST_TX] = ctl.tx_req && !tx_prev_r;
    ev[ST_WD] = ctl.wd_expired && !wd_prev_r;
    level = 8'h00;
    level[ST_RX] = ctl.rx_req;
    level[ST_TX] = ctl.tx_req;
    level[ST_WD] = ctl.wd_expired;
  end

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    mask_nxt = mask_r;
    if (wr_mode) begin
      mode_nxt = reg_wdata & MODE_WMASK;
    end
    if (wr_mask) begin
      mask_nxt = reg_wdata;
    end
    // read clears, a new event in the same cycle survives
    stat_nxt = (rd_stat ? STAT_RST : stat_r) | ev;
    rdata_nxt = RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: rdata_nxt = mode_r;
        ADDR_STAT: rdata_nxt = stat_r;
        ADDR_MASK: rdata_nxt = mask_r;
        ADDR_LEVEL: rdata_nxt = level;
        default: rdata_nxt = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= MODE_RST;
      stat_r <= STAT_RST;
      mask_r <= MASK_RST;
      rdata_r <= RDATA_RST;
      rx_prev_r <= 1'b0;
      tx_prev_r <= 1'b0;
      wd_prev_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      rx_prev_r <= ctl.rx_req;
      tx_prev_r <= ctl.tx_req;
      wd_prev_r <= ctl.wd_expired;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign rx_irq_req = ctl.rx_req || ctl.wd_expired;
  assign tx_irq_req = ctl.tx_req;
  assign fifo_big_mode = mode_r[BIT_BIG];
  assign baud_ext1 = mode_r[BIT_BAUD_X1];
  assign baud_ext2 = mode_r[BIT_BAUD_X2];
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_mode_write;
    reg_wr && reg_addr == ADDR_MODE;
  endsequence

  sequence s_stat_read;
    reg_rd && reg_addr == ADDR_STAT;
  endsequence

  mode_write_a: assert property (s_mode_write |=> mode_r == ($past(reg_wdata) & MODE_WMASK))
    else $error("mode register write not stored");
  rsvd_zero_a: assert property (mode_r[BIT_RSVD] == 1'b0)
    else $error("reserved mode bit not zero");
  wd_enable_a: assert property (s_mode_write ##1 !reg_wr [*2] |-> ctl.wd_en == $past(reg_wdata[BIT_WD_EN], 2))
    else $error("watchdog enable does not follow mode bit 7");
  depth_sel_a: assert property (s_mode_write |=> fifo_big_mode == $past(reg_wdata[BIT_BIG]))
    else $error("fifo depth select does not follow mode bit 3");
  baud_group_a: assert property (s_mode_write |=> baud_ext2 == $past(reg_wdata[BIT_BAUD_X2])
    && baud_ext1 == $past(reg_wdata[BIT_BAUD_X1]))
    else $error("baud group bits do not follow mode write");
  mode_read_a: assert property (reg_rd && reg_addr == ADDR_MODE |=> reg_rdata == $past(mode_r))
    else $error("mode read data wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == RDATA_RST)
    else $error("read data not zero outside read cycle");
  stat_clear_a: assert property (s_stat_read ##0 ev == 8'h00 |=> stat_r == STAT_RST)
    else $error("status read does not clear");
  set_wins_a: assert property (s_stat_read ##0 ev[ST_WD] |=> stat_r[ST_WD])
    else $error("watchdog event lost against clear");
  rx_event_a: assert property ($rose(ctl.rx_req) |=> stat_r[ST_RX])
    else $error("receive event not recorded");
  irq_mask_a: assert property (stat_r[ST_TX] && mask_r[ST_TX] |-> irq)
    else $error("unmasked status does not raise interrupt");
  irq_quiet_a: assert property (mask_r == 8'h00 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule : ufm_mode_ctrl
`default_nettype wire

//--- verif/ufm_fifo_model.sv
// behavioural model of the fifo and receiver side around the mode control block
`timescale 1ns/1ps
`default_nettype none
module ufm_fifo_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // commands from the bench
  input wire logic [8:0] rx_cnt_set,
  input wire logic [8:0] tx_cnt_set,
  input wire logic rx_pop,
  input wire logic tick_run,
  // fifo side signals
  output logic [8:0] receive_queue_count,
  output logic receive_queue_access,
  output logic rx_bit_tick,
  output logic [8:0] tx_queue_count
);
  logic [1:0] div_r;
  // ----------------------------------------------------------------
  // fill levels, host access pulse, 1x bit tick every 4 clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 2'h0;
      rx_bit_tick <= 1'b0;
      receive_queue_access <= 1'b0;
      receive_queue_count <= 9'h000;
      tx_queue_count <= 9'h000;
    end else begin
      div_r <= div_r + 2'h1;
      rx_bit_tick <= tick_run && (div_r == 2'h3);
      receive_queue_access <= rx_pop;
      receive_queue_count <= rx_cnt_set;
      tx_queue_count <= tx_cnt_set;
    end
  end
endmodule : ufm_fifo_model
`default_nettype wire

//--- verif/uart_fifo_irq_mode_control_bench.sv
// self-checking bench for the fifo interrupt mode control block
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_irq_mode_control_bench;
  import ufm_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, lo, rx_pop, tick_run, tx_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [8:0] rx_cnt_set, tx_cnt_set, rq_cnt, tq_cnt;
  logic rq_acc, tick, rx_irq_req, tx_irq_req, fifo_big_mode, baud_ext1, baud_ext2, irq;
  int fails, n_compared, cyc;
  int rmin[4] = '{1, 4, 6, 8};
  int tmax[4] = '{0, 2, 4, 7};
  // ----------------------------------------------------------------
  // design and fifo model
  // ----------------------------------------------------------------
  ufm_mode_ctrl #(.CW(9), .WD_TICKS(4)) dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .secondary_rx_thr_lo(lo), .receive_queue_count(rq_cnt), .receive_queue_access(rq_acc),
    .rx_bit_tick(tick), .tx_queue_count(tq_cnt), .tx_enable(tx_enable),
    .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .fifo_big_mode(fifo_big_mode),
    .baud_ext1(baud_ext1), .baud_ext2(baud_ext2), .irq(irq));
  ufm_fifo_model fifo_u (.clk(clk), .rstn(rstn), .rx_cnt_set(rx_cnt_set),
    .tx_cnt_set(tx_cnt_set), .rx_pop(rx_pop), .tick_run(tick_run),
    .receive_queue_count(rq_cnt), .receive_queue_access(rq_acc), .rx_bit_tick(tick),
    .tx_queue_count(tq_cnt));
  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({1'b0, reg_rdata}, {1'b0, exp});
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic setc(input logic [8:0] rxv, input logic [8:0] txv);
    @(posedge clk);
    rx_cnt_set <= rxv;
    tx_cnt_set <= txv;
    settle();
  endtask : setc
  task automatic ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk);
      if (tick === 1'b1) k++;
    end
    #1;
  endtask : ticks
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, lo, rx_pop, tick_run, tx_enable} = 7'h00;
    {reg_addr, reg_wdata, rx_cnt_set, tx_cnt_set} = 34'h0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_MODE, MODE_RST);
    @(posedge clk);
    #1;
    chk({1'b0, reg_rdata}, 9'h000);
    rd(ADDR_STAT, STAT_RST);
    rd(8'h40, 8'h00);
    wr(ADDR_MASK, 8'h01 << ST_TX);
    rd(ADDR_MASK, 8'h01 << ST_TX);
    chk(tx_irq_req, 9'h000);
    @(posedge clk);
    tx_enable <= 1'b1;
    settle();
    chk(tx_irq_req, 9'h001);
    chk(irq, 9'h001);
    rd(ADDR_STAT, 8'h01 << ST_TX);
    chk(irq, 9'h000);
    setc(9'h000, 9'h001);
    chk(tx_irq_req, 9'h000);
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, 8'h00);
    // mode bits and reserved bit
    wr(ADDR_MODE, 8'hFD);
    rd(ADDR_MODE, MODE_WMASK);
    chk(baud_ext1, 9'h001);
    chk(baud_ext2, 9'h001);
    wr(ADDR_MODE, 8'h08);
    settle();
    chk(fifo_big_mode, 9'h001);
    chk(baud_ext2, 9'h000);
    chk(baud_ext1, 9'h000);
    // threshold codes in 8 deep mode
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE, {1'b0, c[1], c[1:0], 4'h0});
      @(posedge clk);
      lo <= c[0];
      setc(9'(rmin[c] - 1), 9'(tmax[c] + 1));
      chk(rx_irq_req, 9'h000);
      chk(tx_irq_req, 9'h000);
      setc(9'(rmin[c]), 9'(tmax[c]));
      chk(rx_irq_req, 9'h001);
      chk(tx_irq_req, 9'h001);
    end
    chk(fifo_big_mode, 9'h000);
    // 256 deep mode
    wr(ADDR_MODE, 8'h78);
    setc(9'd255, 9'd256);
    chk(rx_irq_req, 9'h000);
    chk(tx_irq_req, 9'h000);
    setc(9'd256, 9'd255);
    chk(rx_irq_req, 9'h001);
    chk(tx_irq_req, 9'h001);
    // receive watchdog, threshold code 11 keeps the fill request low
    wr(ADDR_MODE, 8'hC0);
    setc(9'h002, 9'h001);
    chk(rx_irq_req, 9'h000);
    @(posedge clk);
    tick_run <= 1'b1;
    ticks(3);
    chk(rx_irq_req, 9'h000);
    ticks(1);
    @(posedge clk);
    #1;
    chk(rx_irq_req, 9'h001);
    @(posedge clk);
    rx_pop <= 1'b1;
    rx_cnt_set <= 9'h001;
    @(posedge clk);
    rx_pop <= 1'b0;
    settle();
    chk(rx_irq_req, 9'h000);
    ticks(2);
    chk(rx_irq_req, 9'h000);
    wr(ADDR_MODE, 8'h40);
    ticks(6);
    chk(rx_irq_req, 9'h000);
    wr(ADDR_MODE, 8'hC0);
    ticks(3);
    chk(rx_irq_req, 9'h000);
    ticks(1);
    @(posedge clk);
    #1;
    chk(rx_irq_req, 9'h001);
    tick_run <= 1'b0;
    // sticky status against the mask
    wr(ADDR_MASK, 8'h00);
    settle();
    chk(irq, 9'h000);
    wr(ADDR_MASK, 8'h01 << ST_WD);
    settle();
    chk(irq, 9'h001);
    rd(ADDR_STAT, 8'h07);
    settle();
    chk(irq, 9'h000);
    rd(ADDR_STAT, 8'h00);
    rd(ADDR_LEVEL, 8'h01 << ST_WD);
    test_done();
  end
endmodule : uart_fifo_irq_mode_control_bench
`default_nettype wire
